// ---- bench/hsl_seq_loop_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module hsl_seq_loop_properties
    import hsl_pkg::*;
#(
    parameter int SLOTS = HSL_SLOTS
)(
    input wire logic                      sys_clk,
    input wire logic                      rst_n,
    input wire logic [7:0]                reg_addr,
    input wire logic [7:0]                reg_wdata,
    input wire logic                      reg_wr,
    input wire logic                      reg_rd,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      launch,
    input wire logic                      trigger,
    input wire logic [SLOTS*HSL_ID_W-1:0] slot_ids,
    input wire logic [HSL_REPEAT_W-1:0]   sequence_repeat_count,
    input wire logic [7:0]                overdrive_time_adjust,
    input wire logic [7:0]                positive_sustain_adjust,
    input wire logic                      playing,
    input wire logic [HSL_ID_W-1:0]       effect_id,
    input wire logic                      effect_start,
    input wire logic [2:0]                pass_cnt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_WR_REPEAT: assert property (reg_wr && reg_addr == HSL_ADDR_REPEAT |=> sequence_repeat_count == $past(reg_wdata[2:0])) else $error("repeat field not written");
    AST_WR_OD: assert property (reg_wr && reg_addr == HSL_ADDR_OD_ADJ |=> overdrive_time_adjust == $past(reg_wdata)) else $error("overdrive adjust not written");
    AST_WR_PS: assert property (reg_wr && reg_addr == HSL_ADDR_PS_ADJ |=> positive_sustain_adjust == $past(reg_wdata)) else $error("sustain adjust not written");
    AST_RD_OD: assert property (reg_rd && reg_addr == HSL_ADDR_OD_ADJ |=> reg_rdata == $past(overdrive_time_adjust)) else $error("overdrive readback wrong");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read cycle");
    AST_STOP: assert property (trigger || !launch |=> !playing) else $error("playback not stopped");
    AST_LAUNCH: assert property ($rose(launch) && !trigger && !playing && slot_ids[6:0] != 0 |-> ##2 effect_start) else $error("start latency wrong");
    AST_ZERO_ID: assert property (effect_start |-> effect_id != 0 ##1 !effect_start) else $error("zero id started");
    AST_FOREVER: assert property (sequence_repeat_count == HSL_REPEAT_FOREVER && playing |=> $stable(pass_cnt)) else $error("pass count moved in forever mode");
    COV_START: cover property (effect_start);
    COV_LOOP: cover property (playing && pass_cnt != 0);
    COV_TRIG: cover property (trigger && playing);
endmodule
`default_nettype wire

// ---- bench/tb_hsl_seq_loop.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_hsl_seq_loop
    import hsl_pkg::*;
;
    logic sys_clk, rst_n, reg_wr, reg_rd, launch, trigger, closed_loop, seg_start, effect_done, seg_hold;
    logic playing, effect_start;
    logic [6:0] eid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, step, od, ps, rdv;
    logic signed [7:0] sample, wave_max;
    logic [55:0] ids, full_ids;
    logic [15:0] seg_len;
    logic [2:0] rep, sidx, pcnt;
    int failures, n_tests, n_start, base, got, cyc;
    hsl_seq_loop i_hsl_seq_loop (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_step_period(step), .launch(launch),
        .trigger(trigger), .closed_loop(closed_loop), .slot_ids(ids), .sample(sample), .wave_max(wave_max),
        .seg_len(seg_len), .seg_start(seg_start), .effect_done(effect_done), .sequence_repeat_count(rep),
        .overdrive_time_adjust(od), .positive_sustain_adjust(ps), .playing(playing), .effect_id(eid),
        .effect_start(effect_start), .slot_idx(sidx), .pass_cnt(pcnt), .seg_hold(seg_hold));
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    // far side finishes each effect one cycle after it starts
    // cyc counts edges since reset release, in step with the design's divider
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            effect_done <= 1'b0;
            n_start     <= 0;
            cyc         <= 0;
        end else begin
            effect_done <= effect_start;
            cyc         <= cyc + 1;
            if (effect_start === 1'b1) n_start <= n_start + 1;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %0h expected %0h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    task automatic run_seq(input logic [55:0] v, input logic [2:0] c, input int e);
        int k, s0;
        wr(HSL_ADDR_REPEAT, {5'h00, c});
        ids <= v;
        s0 = n_start;
        @(posedge sys_clk) launch <= 1'b1;
        for (k = 0; k < 1000 && (k < 3 || playing !== 1'b0); k++) @(posedge sys_clk);
        launch <= 1'b0;
        chk(n_start - s0, e, "effects played");
    endtask
    task automatic seg_run(input logic signed [7:0] s);
        // load on a fixed sample step phase so lengths compare exactly
        @(posedge sys_clk);
        while (cyc % (step + 1) != 0) @(posedge sys_clk);
        {sample, wave_max, seg_start} <= {s, 8'sh14, 1'b1};
        @(posedge sys_clk) seg_start <= 1'b0;
        #1 got = 0;
        while (seg_hold === 1'b1 && got < 2000) begin
            @(posedge sys_clk);
            #1 got++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000 failures++;
        finish_test;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, launch, trigger, closed_loop, seg_start} = '0;
        {reg_addr, reg_wdata, sample, wave_max, ids} = '0;
        failures = 0;
        n_tests  = 0;
        step = 8'h01;
        seg_len = 16'h0004;
        for (int i = 0; i < 8; i++) full_ids[i*7+:7] = 7'(i + 1);
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 8'h19; a <= 8'h1c; a++) begin
            rd(8'(a));
            chk(rdv, 8'h00, "reset value");
            wr(8'(a), 8'(8'ha5 + a));
            rd(8'(a));
            chk(rdv, (a == 8'h1c) ? 8'h00 : 8'(8'ha5 + a), "readback");
        end
        $display("test registers done");
        for (int c = 0; c < 7; c++) run_seq(56'h101, 3'(c), 2 * (c + 1));
        run_seq(full_ids, 3'h1, 16);
        chk(eid, 7'h08, "last effect id");
        chk(sidx, 3'h7, "last slot index");
        chk(pcnt, 3'h1, "final pass count");
        run_seq(56'h0, 3'h0, 0);
        $display("test repeat done");
        ids <= 56'h101;
        wr(HSL_ADDR_REPEAT, {5'h00, HSL_REPEAT_FOREVER});
        #1 chk(rep, HSL_REPEAT_FOREVER, "repeat field exported");
        @(posedge sys_clk) launch <= 1'b1;
        repeat (100) @(posedge sys_clk);
        chk(playing, 1'b1, "forever still playing");
        trigger <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(playing, 1'b0, "trigger stop");
        {trigger, launch} <= 2'b00;
        $display("test forever done");
        wr(HSL_ADDR_OD_ADJ, 8'h00);
        wr(HSL_ADDR_PS_ADJ, 8'h00);
        seg_run(8'sh14);
        base = got;
        wr(HSL_ADDR_OD_ADJ, 8'h02);
        #1 chk(od, 8'h02, "overdrive field exported");
        seg_run(8'sh14);
        chk(got, base + 4, "overdrive extended");
        @(posedge sys_clk) closed_loop <= 1'b1;
        seg_run(8'sh14);
        chk(got, base, "closed loop ignores overdrive adjust");
        wr(HSL_ADDR_PS_ADJ, 8'hff);
        #1 chk(ps, 8'hff, "sustain field exported");
        seg_run(8'sh05);
        chk(got, base - 2, "sustain shortened");
        $display("test segments done");
        finish_test;
    end
endmodule
bind hsl_seq_loop hsl_seq_loop_properties #(.SLOTS(SLOTS)) i_hsl_seq_loop_properties (.sys_clk(sys_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .launch(launch), .trigger(trigger), .slot_ids(slot_ids),
    .sequence_repeat_count(sequence_repeat_count), .overdrive_time_adjust(overdrive_time_adjust),
    .positive_sustain_adjust(positive_sustain_adjust), .playing(playing), .effect_id(effect_id),
    .effect_start(effect_start), .pass_cnt(pass_cnt));
`default_nettype wire

// ---- design/hsl_pkg.sv ----
`default_nettype none
package hsl_pkg;
    localparam logic [7:0] HSL_ADDR_REPEAT   = 8'h19;
    localparam logic [7:0] HSL_ADDR_OD_ADJ   = 8'h1a;
    localparam logic [7:0] HSL_ADDR_PS_ADJ   = 8'h1b;
    localparam logic [7:0] HSL_RST_REPEAT    = 8'h00;
    localparam logic [7:0] HSL_RST_OD_ADJ    = 8'h00;
    localparam logic [7:0] HSL_RST_PS_ADJ    = 8'h00;
    localparam int         HSL_REPEAT_LSB    = 0;
    localparam int         HSL_REPEAT_W      = 3;
    localparam logic [2:0] HSL_REPEAT_FOREVER = 3'h7;
    localparam int         HSL_SLOTS         = 8;
    localparam int         HSL_ID_W          = 7;
    localparam int         HSL_DUR_W         = 16;
    localparam int         HSL_SAMP_W        = 8;
    localparam int         HSL_STEP_W        = 8;
endpackage
`default_nettype wire

// ---- design/hsl_seg_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
// stretches or shrinks one waveform segment by a signed count of sample steps
module hsl_seg_timer
    import hsl_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  load,
    input  wire logic [HSL_DUR_W-1:0]  base_len,
    input  wire logic [7:0]            adj,
    input  wire logic                  adj_en,
    input  wire logic                  step_en,
    output logic                       busy
);
    logic [HSL_DUR_W:0] cnt_q;

    function automatic logic [HSL_DUR_W:0] adj_len(input logic [HSL_DUR_W-1:0] b, input logic [7:0] a);
        logic signed [HSL_DUR_W+1:0] s;
        s = $signed({2'b00, b}) + $signed({{(HSL_DUR_W-6){a[7]}}, a});
        if (s < 0)
            return '0;
        return s[HSL_DUR_W:0];
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            cnt_q <= '0;
        else if (load)
            cnt_q <= adj_en ? adj_len(base_len, adj) : {1'b0, base_len};
        else if (step_en && cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    assign busy = (cnt_q != '0);
endmodule
`default_nettype wire

// ---- design/hsl_seq_loop.sv ----
`timescale 1ns/100ps
`default_nettype none
module hsl_seq_loop
    import hsl_pkg::*;
#(
    parameter int SLOTS = HSL_SLOTS
)(
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic [7:0]                        reg_rdata,
    input  wire logic [HSL_STEP_W-1:0]        sample_step_period,
    input  wire logic                         launch,
    input  wire logic                         trigger,
    input  wire logic                         closed_loop,
    input  wire logic [SLOTS*HSL_ID_W-1:0]    slot_ids,
    input  wire logic signed [HSL_SAMP_W-1:0] sample,
    input  wire logic signed [HSL_SAMP_W-1:0] wave_max,
    input  wire logic [HSL_DUR_W-1:0]         seg_len,
    input  wire logic                         seg_start,
    input  wire logic                         effect_done,
    output logic [HSL_REPEAT_W-1:0]           sequence_repeat_count,
    output logic [7:0]                        overdrive_time_adjust,
    output logic [7:0]                        positive_sustain_adjust,
    output logic                              playing,
    output logic [HSL_ID_W-1:0]               effect_id,
    output logic                              effect_start,
    output logic [2:0]                        slot_idx,
    output logic [2:0]                        pass_cnt,
    output logic                              seg_hold
);
    typedef enum logic [1:0] {
        HSL_IDLE  = 2'b00,
        HSL_FETCH = 2'b01,
        HSL_PLAY  = 2'b10
    } hsl_state_t;

    hsl_state_t                 state_q;
    logic [7:0]                 repeat_reg_q;
    logic [7:0]                 od_adj_q;
    logic [7:0]                 ps_adj_q;
    logic [2:0]                 slot_q;
    logic [2:0]                 pass_q;
    logic [HSL_ID_W-1:0]        id_q;
    logic                       start_q;
    logic [7:0]                 rdata_q;
    logic [HSL_STEP_W-1:0]      div_q;
    logic                       step_en;
    logic                       launch_q;
    logic                       stop;
    logic                       is_od;
    logic                       is_ps;
    logic                       od_busy;
    logic                       ps_busy;
    logic [HSL_ID_W-1:0]        cur_id;
    logic                       last_slot;
    logic                       more_passes;

    function automatic logic [HSL_ID_W-1:0] slot_id(input logic [SLOTS*HSL_ID_W-1:0] ids, input logic [2:0] i);
        return ids[i*HSL_ID_W +: HSL_ID_W];
    endfunction

    // register writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            repeat_reg_q <= HSL_RST_REPEAT;
            od_adj_q     <= HSL_RST_OD_ADJ;
            ps_adj_q     <= HSL_RST_PS_ADJ;
        end else if (reg_wr) begin
            if (reg_addr == HSL_ADDR_REPEAT)
                repeat_reg_q <= reg_wdata;
            else if (reg_addr == HSL_ADDR_OD_ADJ)
                od_adj_q <= reg_wdata;
            else if (reg_addr == HSL_ADDR_PS_ADJ)
                ps_adj_q <= reg_wdata;
        end
    end

    // read data one cycle after the strobe, zero when no read is strobed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else if (reg_rd) begin
            if (reg_addr == HSL_ADDR_REPEAT)
                rdata_q <= repeat_reg_q;
            else if (reg_addr == HSL_ADDR_OD_ADJ)
                rdata_q <= od_adj_q;
            else if (reg_addr == HSL_ADDR_PS_ADJ)
                rdata_q <= ps_adj_q;
            else
                rdata_q <= 8'h00;
        end else
            rdata_q <= 8'h00;
    end

    assign reg_rdata = rdata_q;

    assign sequence_repeat_count   = repeat_reg_q[HSL_REPEAT_LSB +: HSL_REPEAT_W];
    assign overdrive_time_adjust   = od_adj_q;
    assign positive_sustain_adjust = ps_adj_q;

    // one enable pulse per sample step
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            div_q <= '0;
        else if (div_q == '0)
            div_q <= sample_step_period;
        else
            div_q <= div_q - 1'b1;
    end

    assign step_en = (div_q == '0);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            launch_q <= 1'b0;
        else
            launch_q <= launch;
    end

    assign stop        = trigger || !launch;
    assign cur_id      = slot_id(slot_ids, slot_q);
    assign last_slot   = (slot_q == 3'(SLOTS-1));
    assign more_passes = (sequence_repeat_count == HSL_REPEAT_FOREVER) ||
                         (pass_q < sequence_repeat_count);

    // sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HSL_IDLE;
            slot_q  <= '0;
            pass_q  <= '0;
            id_q    <= '0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (state_q)
                HSL_IDLE: begin
                    if (launch && !launch_q && !trigger) begin
                        slot_q  <= '0;
                        pass_q  <= '0;
                        state_q <= HSL_FETCH;
                    end
                end
                HSL_FETCH: begin
                    if (stop)
                        state_q <= HSL_IDLE;
                    else if (cur_id == '0) begin
                        if (slot_q != '0 && more_passes) begin
                            pass_q <= (sequence_repeat_count == HSL_REPEAT_FOREVER) ? pass_q : pass_q + 1'b1;
                            slot_q <= '0;
                        end else
                            state_q <= HSL_IDLE;
                    end else begin
                        id_q    <= cur_id;
                        start_q <= 1'b1;
                        state_q <= HSL_PLAY;
                    end
                end
                HSL_PLAY: begin
                    if (stop)
                        state_q <= HSL_IDLE;
                    else if (effect_done) begin
                        if (!last_slot) begin
                            slot_q  <= slot_q + 1'b1;
                            state_q <= HSL_FETCH;
                        end else if (more_passes) begin
                            pass_q  <= (sequence_repeat_count == HSL_REPEAT_FOREVER) ? pass_q : pass_q + 1'b1;
                            slot_q  <= '0;
                            state_q <= HSL_FETCH;
                        end else
                            state_q <= HSL_IDLE;
                    end
                end
                default: state_q <= HSL_IDLE;
            endcase
        end
    end

    assign playing      = (state_q != HSL_IDLE);
    assign effect_id    = id_q;
    assign effect_start = start_q;
    assign slot_idx     = slot_q;
    assign pass_cnt     = pass_q;

    hsl_wave_class u_class (
        .sample         (sample),
        .wave_max       (wave_max),
        .is_overdrive   (is_od),
        .is_pos_sustain (is_ps)
    );

    hsl_seg_timer u_od (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .load     (seg_start && is_od),
        .base_len (seg_len),
        .adj      (od_adj_q),
        .adj_en   (!closed_loop),
        .step_en  (step_en),
        .busy     (od_busy)
    );

    hsl_seg_timer u_ps (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .load     (seg_start && is_ps),
        .base_len (seg_len),
        .adj      (ps_adj_q),
        .adj_en   (1'b1),
        .step_en  (step_en),
        .busy     (ps_busy)
    );

    assign seg_hold = od_busy || ps_busy;
endmodule
`default_nettype wire

// ---- design/hsl_wave_class.sv ----
`timescale 1ns/100ps
`default_nettype none
// tags one library sample as overdrive, positive sustain or other
module hsl_wave_class
    import hsl_pkg::*;
(
    input  wire logic signed [HSL_SAMP_W-1:0] sample,
    input  wire logic signed [HSL_SAMP_W-1:0] wave_max,
    output logic                              is_overdrive,
    output logic                              is_pos_sustain
);
    assign is_overdrive   = (sample == wave_max) && (sample > 0);
    assign is_pos_sustain = (sample > 0) && !is_overdrive;
endmodule
`default_nettype wire
